// ### hdl/ucs_regs.sv
// Upstream command and status configuration registers
`timescale 1ns/1ps
`include "ucs_cfg.svh"
module ucs_regs
(
  input  wire logic                  CLK,
  input  wire logic                  RST_N,
  input  wire logic                  CFG_WR,
  input  wire logic                  CFG_RD,
  input  wire ucs_pkg::ucs_addr_type CFG_ADDR,
  input  wire ucs_pkg::ucs_word_type CFG_WDATA,
  input  wire logic [1:0]            CFG_BE,
  output logic                       CFG_RVALID,
  output ucs_pkg::ucs_word_type      CFG_RDATA,
  input  wire logic                  EV_POISON_RX,
  input  wire logic                  EV_POISON_CPL_RX,
  input  wire logic                  EV_POISON_WR_RX,
  input  wire logic                  EV_ERR_MSG_TX,
  input  wire logic                  EV_CPL_UR_RX,
  input  wire logic                  EV_CPL_CA_RX,
  input  wire logic                  EV_CPL_CA_TX,
  output logic                       INITIATOR_ENABLE,
  output logic                       MEM_DECODE_ENABLE,
  output logic                       PORT_SPACE_DECODE_ENABLE,
  output logic                       WRITE_INVALIDATE_PROMOTE_ENABLE,
  output logic                       SYSTEM_ERROR_REPORT_ENABLE,
  output logic                       PARITY_RESPONSE_ENABLE
);
  import ucs_pkg::*;

  ucs_word_type cmd_q;
  ucs_word_type sts_q;
  ucs_word_type be_mask;
  ucs_word_type sts_set;
  ucs_word_type sts_clr;
  logic         cmd_wr;
  logic         sts_wr;

  assign be_mask = {{8{CFG_BE[1]}}, {8{CFG_BE[0]}}};
  assign cmd_wr  = CFG_WR && (CFG_ADDR == `UCS_CMD_OFFSET);
  assign sts_wr  = CFG_WR && (CFG_ADDR == `UCS_STS_OFFSET);

  // Only implemented control bits are writable; others stay zero
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      cmd_q <= `UCS_CMD_RESET;
    else if (cmd_wr)
      cmd_q <= (cmd_q & ~(be_mask & `UCS_CMD_WR_MASK)) | (CFG_WDATA & be_mask & `UCS_CMD_WR_MASK);
  end

  // Event set terms
  always_comb
  begin
    sts_set = 16'h0000;
    sts_set[`UCS_STS_PPD_BIT] = EV_POISON_RX;
    sts_set[`UCS_STS_SES_BIT] = EV_ERR_MSG_TX && cmd_q[`UCS_CMD_SERR_BIT];
    sts_set[`UCS_STS_URR_BIT] = EV_CPL_UR_RX;
    sts_set[`UCS_STS_CAR_BIT] = EV_CPL_CA_RX;
    sts_set[`UCS_STS_CAS_BIT] = EV_CPL_CA_TX;
    sts_set[`UCS_STS_MPE_BIT] = cmd_q[`UCS_CMD_PERR_BIT] && (EV_POISON_CPL_RX || EV_POISON_WR_RX);
  end

  assign sts_clr = sts_wr ? (CFG_WDATA & be_mask & `UCS_STS_W1C_MASK) : 16'h0000;

  // Sticky flags, set beats write-one-to-clear
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      sts_q <= `UCS_STS_RESET;
    else
      sts_q <= ((sts_q & ~sts_clr) | sts_set) & `UCS_STS_W1C_MASK | `UCS_STS_RESET;
  end

  // Read port, one cycle after request
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      CFG_RVALID <= 1'b0;
      CFG_RDATA  <= 16'h0000;
    end
    else
    begin
      CFG_RVALID <= CFG_RD;
      if (CFG_RD && CFG_ADDR == `UCS_CMD_OFFSET)
        CFG_RDATA <= cmd_q;
      else if (CFG_RD && CFG_ADDR == `UCS_STS_OFFSET)
        CFG_RDATA <= sts_q;
      else
        CFG_RDATA <= 16'h0000;
    end
  end

  // Control outputs registered from command bits
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      INITIATOR_ENABLE                <= 1'b0;
      MEM_DECODE_ENABLE               <= 1'b0;
      PORT_SPACE_DECODE_ENABLE        <= 1'b0;
      WRITE_INVALIDATE_PROMOTE_ENABLE <= 1'b0;
      SYSTEM_ERROR_REPORT_ENABLE      <= 1'b0;
      PARITY_RESPONSE_ENABLE          <= 1'b0;
    end
    else
    begin
      INITIATOR_ENABLE                <= cmd_q[`UCS_CMD_INIT_BIT];
      MEM_DECODE_ENABLE               <= cmd_q[`UCS_CMD_MEM_BIT];
      PORT_SPACE_DECODE_ENABLE        <= cmd_q[`UCS_CMD_PORT_BIT];
      WRITE_INVALIDATE_PROMOTE_ENABLE <= cmd_q[`UCS_CMD_MWI_BIT];
      SYSTEM_ERROR_REPORT_ENABLE      <= cmd_q[`UCS_CMD_SERR_BIT];
      PARITY_RESPONSE_ENABLE          <= cmd_q[`UCS_CMD_PERR_BIT];
    end
  end

  a_palette_reads_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    cmd_q[5] == 1'b0 && cmd_q[3] == 1'b0) else $error("command bits 5 or 3 nonzero");
  a_broadcast_reads_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    CFG_RD && CFG_ADDR == `UCS_CMD_OFFSET |=> CFG_RDATA[3] == 1'b0) else $error("command bit 3 read one");
  a_cap_bit_one: assert property (@(posedge CLK) disable iff (!RST_N)
    CFG_RD && CFG_ADDR == `UCS_STS_OFFSET |=> CFG_RDATA[4] == 1'b1) else $error("capability bit not one");
  a_status_fixed_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    (sts_q & 16'h06ef) == 16'h0000) else $error("fixed status bits nonzero");
  a_poison_sets_flag: assert property (@(posedge CLK) disable iff (!RST_N)
    EV_POISON_RX |=> sts_q[15]) else $error("poison flag not set");
  a_serr_gated: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(sts_q[14]) |-> $past(EV_ERR_MSG_TX) && $past(cmd_q[8])) else $error("system error flag set without cause");
  a_mpe_gated: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(sts_q[8]) |-> $past(cmd_q[6])) else $error("master poison set with parity response off");
  a_sticky_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    sts_q[12] && !(sts_wr && CFG_WDATA[12] && CFG_BE[1]) |=> sts_q[12]) else $error("sticky flag lost");
  sequence s_cmd_write;
    cmd_wr && CFG_BE[0] && CFG_WDATA[1];
  endsequence
  a_mem_enable_out: assert property (@(posedge CLK) disable iff (!RST_N)
    s_cmd_write ##1 !cmd_wr |=> MEM_DECODE_ENABLE) else $error("memory decode enable not driven");
  a_abort_rx_sets: assert property (@(posedge CLK) disable iff (!RST_N)
    EV_CPL_CA_RX |=> sts_q[12] ##1 1'b1) else $error("completer abort received not set");

  sequence s_cmd_full_write;
    cmd_wr && CFG_BE == 2'b11;
  endsequence

  sequence s_clear_ppd;
    sts_wr && CFG_BE[1] && CFG_WDATA[15] && !EV_POISON_RX;
  endsequence

  sequence s_clear_mpe;
    sts_wr && CFG_BE[1] && CFG_WDATA[8] && !EV_POISON_CPL_RX && !EV_POISON_WR_RX;
  endsequence

  sequence s_abort_clear_clash;
    EV_CPL_CA_RX && sts_wr && CFG_BE[1] && CFG_WDATA[12];
  endsequence

  a_perr_out_on: assert property (@(posedge CLK) disable iff (!RST_N)
    cmd_q[6] |=> PARITY_RESPONSE_ENABLE)
    else $error("parity response enable not driven");

  a_perr_out_off: assert property (@(posedge CLK) disable iff (!RST_N)
    !cmd_q[6] |=> !PARITY_RESPONSE_ENABLE)
    else $error("parity response enable driven while off");

  a_mpe_blocked: assert property (@(posedge CLK) disable iff (!RST_N)
    !cmd_q[6] && !sts_q[8] |=> !sts_q[8])
    else $error("master poison set with parity response off");

  a_palette_read_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    CFG_RD && CFG_ADDR == `UCS_CMD_OFFSET |=> !CFG_RDATA[5])
    else $error("palette snoop bit read one");

  a_cmd_write_lands: assert property (@(posedge CLK) disable iff (!RST_N)
    s_cmd_full_write |=> cmd_q == ($past(CFG_WDATA) & `UCS_CMD_WR_MASK))
    else $error("command write not masked to writable bits");

  a_promote_out_on: assert property (@(posedge CLK) disable iff (!RST_N)
    cmd_q[4] |=> WRITE_INVALIDATE_PROMOTE_ENABLE)
    else $error("promotion enable not driven");

  a_promote_out_off: assert property (@(posedge CLK) disable iff (!RST_N)
    !cmd_q[4] |=> !WRITE_INVALIDATE_PROMOTE_ENABLE)
    else $error("promotion enable driven while off");

  a_broadcast_held_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    cmd_wr && CFG_BE[0] && CFG_WDATA[3] |=> !cmd_q[3])
    else $error("broadcast response bit took a write");

  a_initiator_out_on: assert property (@(posedge CLK) disable iff (!RST_N)
    cmd_q[2] |=> INITIATOR_ENABLE)
    else $error("initiator enable not driven");

  a_initiator_out_off: assert property (@(posedge CLK) disable iff (!RST_N)
    !cmd_q[2] |=> !INITIATOR_ENABLE)
    else $error("initiator enable driven while off");

  a_mem_decode_off: assert property (@(posedge CLK) disable iff (!RST_N)
    !cmd_q[1] |=> !MEM_DECODE_ENABLE)
    else $error("memory decode enable driven while off");

  a_port_decode_on: assert property (@(posedge CLK) disable iff (!RST_N)
    cmd_q[0] |=> PORT_SPACE_DECODE_ENABLE)
    else $error("port decode enable not driven");

  a_port_decode_off: assert property (@(posedge CLK) disable iff (!RST_N)
    !cmd_q[0] |=> !PORT_SPACE_DECODE_ENABLE)
    else $error("port decode enable driven while off");

  a_cap_bit_held: assert property (@(posedge CLK) disable iff (!RST_N)
    sts_q[4])
    else $error("capability bit lost");

  a_poison_flag_cause: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(sts_q[15]) |-> $past(EV_POISON_RX))
    else $error("poison flag set without cause");

  a_serr_flag_sets: assert property (@(posedge CLK) disable iff (!RST_N)
    EV_ERR_MSG_TX && cmd_q[8] |=> sts_q[14])
    else $error("system error flag not set");

  a_serr_flag_blocked: assert property (@(posedge CLK) disable iff (!RST_N)
    EV_ERR_MSG_TX && !cmd_q[8] && !sts_q[14] |=> !sts_q[14])
    else $error("system error flag set while reporting off");

  a_ur_flag_sets: assert property (@(posedge CLK) disable iff (!RST_N)
    EV_CPL_UR_RX |=> sts_q[13])
    else $error("unsupported completion flag not set");

  a_ur_flag_cause: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(sts_q[13]) |-> $past(EV_CPL_UR_RX))
    else $error("unsupported completion flag set without cause");

  a_ca_rx_cause: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(sts_q[12]) |-> $past(EV_CPL_CA_RX))
    else $error("abort received flag set without cause");

  a_ca_tx_sets: assert property (@(posedge CLK) disable iff (!RST_N)
    EV_CPL_CA_TX |=> sts_q[11])
    else $error("abort signalled flag not set");

  a_ca_tx_cause: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(sts_q[11]) |-> $past(EV_CPL_CA_TX))
    else $error("abort signalled flag set without cause");

  a_select_timing_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    CFG_RD && CFG_ADDR == `UCS_STS_OFFSET |=> CFG_RDATA[10:9] == 2'b00)
    else $error("select timing field nonzero");

  a_mpe_flag_sets: assert property (@(posedge CLK) disable iff (!RST_N)
    cmd_q[6] && (EV_POISON_CPL_RX || EV_POISON_WR_RX) |=> sts_q[8])
    else $error("master poison flag not set");

  a_mpe_flag_cause: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(sts_q[8]) |-> $past(EV_POISON_CPL_RX) || $past(EV_POISON_WR_RX))
    else $error("master poison flag set without cause");

  a_fixed_read_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    CFG_RD && CFG_ADDR == `UCS_STS_OFFSET |=> (CFG_RDATA & 16'h00e7) == 16'h0000)
    else $error("fixed status bits read nonzero");

  a_int_status_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    CFG_RD && CFG_ADDR == `UCS_STS_OFFSET |=> !CFG_RDATA[3])
    else $error("interrupt status read one");

  a_serr_out_on: assert property (@(posedge CLK) disable iff (!RST_N)
    cmd_q[8] |=> SYSTEM_ERROR_REPORT_ENABLE)
    else $error("system error enable not driven");

  a_serr_out_off: assert property (@(posedge CLK) disable iff (!RST_N)
    !cmd_q[8] |=> !SYSTEM_ERROR_REPORT_ENABLE)
    else $error("system error enable driven while off");

  a_ppd_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    sts_q[15] && !(sts_wr && CFG_BE[1] && CFG_WDATA[15]) |=> sts_q[15])
    else $error("poison flag lost");

  a_ses_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    sts_q[14] && !(sts_wr && CFG_BE[1] && CFG_WDATA[14]) |=> sts_q[14])
    else $error("system error flag lost");

  a_urr_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    sts_q[13] && !(sts_wr && CFG_BE[1] && CFG_WDATA[13]) |=> sts_q[13])
    else $error("unsupported completion flag lost");

  a_cas_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    sts_q[11] && !(sts_wr && CFG_BE[1] && CFG_WDATA[11]) |=> sts_q[11])
    else $error("abort signalled flag lost");

  a_mpe_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    sts_q[8] && !(sts_wr && CFG_BE[1] && CFG_WDATA[8]) |=> sts_q[8])
    else $error("master poison flag lost");

  a_ppd_write_clear: assert property (@(posedge CLK) disable iff (!RST_N)
    s_clear_ppd |=> !sts_q[15])
    else $error("poison flag not cleared by write one");

  a_mpe_write_clear: assert property (@(posedge CLK) disable iff (!RST_N)
    s_clear_mpe |=> !sts_q[8])
    else $error("master poison flag not cleared by write one");

  a_set_beats_clear: assert property (@(posedge CLK) disable iff (!RST_N)
    s_abort_clear_clash |=> sts_q[12])
    else $error("clear won over a new abort event");

  a_rvalid_follows: assert property (@(posedge CLK) disable iff (!RST_N)
    CFG_RD |=> CFG_RVALID)
    else $error("read valid missing");

  a_rvalid_idle: assert property (@(posedge CLK) disable iff (!RST_N)
    !CFG_RD |=> !CFG_RVALID)
    else $error("read valid without read");

  a_rdata_status: assert property (@(posedge CLK) disable iff (!RST_N)
    CFG_RD && CFG_ADDR == `UCS_STS_OFFSET |=> CFG_RDATA == $past(sts_q))
    else $error("status read data wrong");

  a_rdata_command: assert property (@(posedge CLK) disable iff (!RST_N)
    CFG_RD && CFG_ADDR == `UCS_CMD_OFFSET |=> CFG_RDATA == $past(cmd_q))
    else $error("command read data wrong");

  a_unmapped_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    CFG_RD && CFG_ADDR != `UCS_CMD_OFFSET && CFG_ADDR != `UCS_STS_OFFSET |=> CFG_RDATA == 16'h0000)
    else $error("unmapped read nonzero");
endmodule

// ### inc/ucs_cfg.svh
// Offsets, field positions and reset values of the upstream command and status registers
`ifndef UCS_CFG_SVH
`define UCS_CFG_SVH
`define UCS_CMD_OFFSET 8'h04
`define UCS_STS_OFFSET 8'h06
`define UCS_CMD_RESET 16'h0000
`define UCS_STS_RESET 16'h0010
`define UCS_CMD_WR_MASK 16'h0157
`define UCS_STS_W1C_MASK 16'hf900
`define UCS_CMD_PORT_BIT 0
`define UCS_CMD_MEM_BIT 1
`define UCS_CMD_INIT_BIT 2
`define UCS_CMD_MWI_BIT 4
`define UCS_CMD_PERR_BIT 6
`define UCS_CMD_SERR_BIT 8
`define UCS_STS_CAP_BIT 4
`define UCS_STS_MPE_BIT 8
`define UCS_STS_CAS_BIT 11
`define UCS_STS_CAR_BIT 12
`define UCS_STS_URR_BIT 13
`define UCS_STS_SES_BIT 14
`define UCS_STS_PPD_BIT 15
`endif

// ### inc/ucs_pkg.sv
// Types shared by the upstream command and status registers
package ucs_pkg;
  typedef logic [15:0] ucs_word_type;
  typedef logic [7:0]  ucs_addr_type;
endpackage

// ### sim/ucs_link_model.sv
// Link-side event source feeding the status flags
`timescale 1ns/1ps
module ucs_link_model
(
  input  wire logic       clk,
  input  wire logic [6:0] fire,
  output logic [6:0]      ev
);
  // One-cycle pulses; a poisoned completion or write is also a poisoned packet
  always_ff @(posedge clk)
  begin
    ev <= fire | {|fire[5:4], 6'h00};
  end
endmodule

// ### sim/ucs_regs_tb_top.sv
// Self-checking bench for the upstream command and status registers
`timescale 1ns/1ps
module ucs_regs_tb_top;
  import ucs_pkg::*;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         wr = 1'b0;
  logic         rd = 1'b0;
  ucs_addr_type addr = 8'h00;
  ucs_word_type wdata = 16'h0000;
  logic [1:0]   be = 2'h0;
  logic [6:0]   fire = 7'h00;
  logic [6:0]   ev;
  logic         rvalid;
  ucs_word_type rdata;
  logic [5:0]   ctl;
  int           bad_count = 0;
  int           compares = 0;
  always #4 clk = ~clk;
  ucs_link_model link (.clk(clk), .fire(fire), .ev(ev));
  ucs_regs dut (.CLK(clk), .RST_N(rst_n), .CFG_WR(wr), .CFG_RD(rd), .CFG_ADDR(addr), .CFG_WDATA(wdata),
    .CFG_BE(be), .CFG_RVALID(rvalid), .CFG_RDATA(rdata), .EV_POISON_RX(ev[6]), .EV_POISON_CPL_RX(ev[5]),
    .EV_POISON_WR_RX(ev[4]), .EV_ERR_MSG_TX(ev[3]), .EV_CPL_UR_RX(ev[2]), .EV_CPL_CA_RX(ev[1]),
    .EV_CPL_CA_TX(ev[0]), .SYSTEM_ERROR_REPORT_ENABLE(ctl[5]), .PARITY_RESPONSE_ENABLE(ctl[4]),
    .WRITE_INVALIDATE_PROMOTE_ENABLE(ctl[3]), .INITIATOR_ENABLE(ctl[2]), .MEM_DECODE_ENABLE(ctl[1]),
    .PORT_SPACE_DECODE_ENABLE(ctl[0]));
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic drive(input logic w, input logic r, input ucs_addr_type a, input ucs_word_type d,
                       input logic [1:0] b);
    @(posedge clk);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    be <= b;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rdc(input ucs_addr_type a, input ucs_word_type exp);
    drive(1'b0, 1'b1, a, 16'h0000, 2'h0);
    #1;
    chk({rvalid, rdata}, {1'b1, exp});
  endtask
  task automatic pulse(input logic [6:0] v);
    @(posedge clk);
    fire <= v;
    @(posedge clk);
    fire <= 7'h00;
  endtask
  task automatic t_reset;
    chk({11'h000, ctl}, 17'h00000);
    rdc(8'h04, 16'h0000);
    rdc(8'h06, 16'h0010);
    rdc(8'h08, 16'h0000);
  endtask
  task automatic t_command;
    drive(1'b1, 1'b0, 8'h04, 16'hffff, 2'h3);
    rdc(8'h04, 16'h0157);
    chk({11'h000, ctl}, 17'h0003f);
    drive(1'b1, 1'b0, 8'h04, 16'h0000, 2'h1);
    rdc(8'h04, 16'h0100);
    chk({11'h000, ctl}, 17'h00020);
  endtask
  task automatic t_status;
    drive(1'b1, 1'b0, 8'h06, 16'hffff, 2'h3);
    rdc(8'h06, 16'h0010);
    pulse(7'h7f);
    rdc(8'h06, 16'hf810);
    drive(1'b1, 1'b0, 8'h06, 16'h0000, 2'h3);
    rdc(8'h06, 16'hf810);
    drive(1'b1, 1'b0, 8'h06, 16'hffff, 2'h3);
    drive(1'b1, 1'b0, 8'h04, 16'h0040, 2'h3);
    pulse(7'h28);
    rdc(8'h06, 16'h8110);
    drive(1'b1, 1'b0, 8'h06, 16'hff00, 2'h2);
    pulse(7'h10);
    rdc(8'h06, 16'h8110);
  endtask
  task automatic results;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_command;
    t_status;
    results;
  end
endmodule
